// ### app_top.sv
// ACPI power pin control: strap, memory gate, power good, button, pin sharing
//
// Behaviour
// RULE1 - During standby reset pull strap low and latch it as ACPI feature enable.
// RULE2 - Memory gate switches standby rail to memory while in S3.
// RULE3 - Gate function off by default; its enable comes from control bit four.
// RULE4 - Open-drain second power good is raised once host supply is up.
// RULE5 - Supply power good input feeds both power good outputs; on by default.
// RULE6 - Front reset button is debounced for at least 32 ms.
// RULE7 - One pin is either GPIO or open-drain watchdog timeout output.
// RULE8 - Port 5 bit 5 is either GPIO or suspend LED output.
// RULE9 - S5 sleep input pin may instead be GPIO port 3 bit 7.
// RULE10 - Port 3 bits 0,1,5,6 share power good, gate, supply good, button.
// RULE11 - Open-drain resume reset output marks the standby reset window.
// RULE12 - Chipset drives S3 input; used with S5 to track sleep state.
// RULE13 - Second power good drops when supply good or host supply drops.
`timescale 1ns/1ps
module app_top #(
  parameter int unsigned DEBOUNCE_CYCLES = app_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic       CLOCK_I,
  input  wire logic       RESET_I,
  input  wire logic       HOST_SUPPLY_OK_I,
  input  wire logic       SLEEP_S3_N_I,
  input  wire logic       STRAP_I,
  input  wire logic       STANDBY_GATE_EN_I,
  input  wire logic       WATCHDOG_EXPIRED_I,
  input  wire logic [6:0] GPIO_MODE_I,
  input  wire logic [6:0] GPIO_DIR_I,
  input  wire logic [6:0] GPIO_DATA_I,
  input  wire logic [6:0] PIN_I,
  output logic      [6:0] PIN_O,
  output logic      [6:0] PIN_OE_N_O,
  output logic      [6:0] GPIO_IN_O,
  output logic            STRAP_PD_O,
  output logic            RESUME_RESET_O,
  output logic            RESUME_RESET_OE_N_O,
  output logic            ACPI_FEATURE_EN_O,
  output logic            POWER_GOOD_O,
  output logic            POWER_GOOD_OE_N_O,
  output logic            FRONT_RESET_PRESS_O,
  output logic      [1:0] SLEEP_STATE_O
);

  localparam int unsigned HOLD_CYCLES = app_pkg::RESUME_HOLD_CYCLES;
  localparam int unsigned HW          = $clog2(HOLD_CYCLES + 1);

  if (HOLD_CYCLES < 1) begin : g_chk_hold
    $error("Resume reset hold must be at least one cycle");
  end
  if (DEBOUNCE_CYCLES < 1) begin : g_chk_deb
    $error("Debounce length must be at least one cycle");
  end

  // Standby reset sequencer
  app_pkg::app_seq_t seq;
  app_pkg::app_seq_t next_seq;
  logic [HW-1:0]     hold_count;
  logic              hold_done;
  logic              resume_active;

  // Sleep tracking
  app_pkg::app_sleep_t sleep;
  app_pkg::app_sleep_t next_sleep;
  logic                s5_n;
  logic                s3_n;

  // Function side of the shared pins
  logic [6:0] eff_gpio_mode;
  logic [6:0] func_level;
  logic       acpi_en;
  logic       supply_good;
  logic       button_raw_n;
  logic       button_stable_n;
  logic       gate_on;
  logic       good_level;
  logic       led_on;

  assign hold_done     = hold_count == HW'(HOLD_CYCLES - 1);
  assign resume_active = seq != app_pkg::SEQ_RUN;

  always_comb
  begin
    next_seq = seq;
    case (seq)
      app_pkg::SEQ_HOLD:
      begin
        if (hold_done)
        begin
          next_seq = app_pkg::SEQ_LATCH;
        end
      end
      app_pkg::SEQ_LATCH:
      begin
        next_seq = app_pkg::SEQ_RUN;
      end
      app_pkg::SEQ_RUN:
      begin
        next_seq = app_pkg::SEQ_RUN;
      end
      default:
      begin
        next_seq = app_pkg::SEQ_HOLD;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      seq        <= app_pkg::SEQ_HOLD;
      hold_count <= '0;
    end
    else
    begin
      seq <= next_seq;
      if (seq == app_pkg::SEQ_HOLD && !hold_done)
      begin
        hold_count <= hold_count + HW'(1);
      end
    end
  end

  // Strap sampled at the end of the window, after reset release
  always_ff @(posedge CLOCK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      acpi_en <= app_pkg::ACPI_EN_RESET;
    end
    else if (seq == app_pkg::SEQ_LATCH)
    begin
      acpi_en <= STRAP_I; // RULE1
    end
  end

  // Resume reset and strap pull-down follow the window
  always_ff @(posedge CLOCK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      STRAP_PD_O          <= 1'b1;
      RESUME_RESET_O      <= 1'b0;
      RESUME_RESET_OE_N_O <= 1'b0;
      ACPI_FEATURE_EN_O   <= app_pkg::ACPI_EN_RESET;
    end
    else
    begin
      STRAP_PD_O          <= next_seq != app_pkg::SEQ_RUN; // RULE1
      RESUME_RESET_O      <= 1'b0;
      RESUME_RESET_OE_N_O <= next_seq == app_pkg::SEQ_RUN; // RULE11
      ACPI_FEATURE_EN_O   <= acpi_en;
    end
  end

  // Particular ACPI pins fall back to GPIO while the feature is off
  assign eff_gpio_mode = GPIO_MODE_I | ({7{~acpi_en}} & app_pkg::ACPI_PIN_MASK);

  // Sleep inputs; S5 pin released reads inactive in GPIO mode
  assign s5_n = eff_gpio_mode[app_pkg::PIN_P3B7_S5] | PIN_I[app_pkg::PIN_P3B7_S5]; // RULE9
  assign s3_n = SLEEP_S3_N_I; // RULE12

  always_comb
  begin
    next_sleep = app_pkg::SLEEP_S0;
    case ({s5_n, s3_n})
      2'h0:
      begin
        next_sleep = app_pkg::SLEEP_S5;
      end
      2'h1:
      begin
        next_sleep = app_pkg::SLEEP_S5;
      end
      2'h2:
      begin
        next_sleep = app_pkg::SLEEP_S3; // RULE12
      end
      2'h3:
      begin
        next_sleep = app_pkg::SLEEP_S0;
      end
      default:
      begin
        next_sleep = app_pkg::SLEEP_S0;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      sleep <= app_pkg::SLEEP_S0;
    end
    else
    begin
      sleep <= next_sleep;
    end
  end

  assign SLEEP_STATE_O = sleep;

  // Supply good source, read only in its alternate function
  assign supply_good = ~eff_gpio_mode[app_pkg::PIN_P3B5_SUPPLY]
                       & PIN_I[app_pkg::PIN_P3B5_SUPPLY]; // RULE5 RULE10
  assign good_level  = supply_good & HOST_SUPPLY_OK_I; // RULE4 RULE13

  // Memory gate needs feature, control bit and S3
  assign gate_on = acpi_en & STANDBY_GATE_EN_I
                   & (sleep == app_pkg::SLEEP_S3); // RULE2 RULE3

  assign led_on = sleep != app_pkg::SLEEP_S0;

  // Button reads released when its pin is GPIO
  assign button_raw_n = eff_gpio_mode[app_pkg::PIN_P3B6_BUTTON]
                        | PIN_I[app_pkg::PIN_P3B6_BUTTON]; // RULE10

  app_debounce #(
    .CYCLES (DEBOUNCE_CYCLES)
  ) u_button (
    .clk_i    (CLOCK_I),
    .rst_i    (RESET_I),
    .raw_i    (button_raw_n),
    .stable_o (button_stable_n)
  );

  // Primary power good, open drain
  always_ff @(posedge CLOCK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      POWER_GOOD_O        <= 1'b0;
      POWER_GOOD_OE_N_O   <= 1'b0;
      FRONT_RESET_PRESS_O <= 1'b0;
    end
    else
    begin
      POWER_GOOD_O        <= 1'b0;
      POWER_GOOD_OE_N_O   <= good_level; // RULE5
      FRONT_RESET_PRESS_O <= ~button_stable_n; // RULE6
    end
  end

  // Levels offered to the pins in their alternate function
  assign func_level[app_pkg::PIN_P3B0_PG2]    = good_level; // RULE4 RULE10
  assign func_level[app_pkg::PIN_P3B1_GATE]   = ~gate_on; // RULE2 RULE10
  assign func_level[app_pkg::PIN_P3B5_SUPPLY] = 1'b1;
  assign func_level[app_pkg::PIN_P3B6_BUTTON] = 1'b1;
  assign func_level[app_pkg::PIN_P3B7_S5]     = 1'b1;
  assign func_level[app_pkg::PIN_P5B5_LED]    = led_on; // RULE8
  assign func_level[app_pkg::PIN_WDOG]        = ~WATCHDOG_EXPIRED_I; // RULE7

  for (genvar i = 0; i < app_pkg::PIN_COUNT; i++) begin : g_pin
    app_pin_cell #(
      .GPIO_OD (app_pkg::GPIO_OD_MASK[i]),
      .FUNC_OD (app_pkg::FUNC_OD_MASK[i]),
      .FUNC_IN (app_pkg::FUNC_IN_MASK[i])
    ) u_cell (
      .clk_i        (CLOCK_I),
      .rst_i        (RESET_I),
      .gpio_mode_i  (eff_gpio_mode[i]), // RULE7 RULE8 RULE9 RULE10
      .gpio_dir_i   (GPIO_DIR_I[i]),
      .gpio_data_i  (GPIO_DATA_I[i]),
      .func_level_i (func_level[i]),
      .pin_i        (PIN_I[i]),
      .pin_o        (PIN_O[i]),
      .pin_oe_n_o   (PIN_OE_N_O[i]),
      .gpio_in_o    (GPIO_IN_O[i])
    );
  end

endmodule

// ### app_pkg.sv
// Shared constants and types for the ACPI power pin block
package app_pkg;

  // Clock and timing
  localparam int unsigned CLOCK_HZ          = 25_000_000;
  localparam int unsigned DEBOUNCE_MS       = 32;
  localparam int unsigned DEBOUNCE_CYCLES   = (CLOCK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned RESUME_HOLD_US    = 10;
  localparam int unsigned RESUME_HOLD_CYCLES = (CLOCK_HZ / 1_000_000) * RESUME_HOLD_US;

  // Shared pin indices
  localparam int unsigned PIN_COUNT         = 7;
  localparam int unsigned PIN_P3B0_PG2      = 0;
  localparam int unsigned PIN_P3B1_GATE     = 1;
  localparam int unsigned PIN_P3B5_SUPPLY   = 2;
  localparam int unsigned PIN_P3B6_BUTTON   = 3;
  localparam int unsigned PIN_P3B7_S5       = 4;
  localparam int unsigned PIN_P5B5_LED      = 5;
  localparam int unsigned PIN_WDOG          = 6;

  // Pin kinds per index
  localparam logic [6:0] GPIO_OD_MASK       = 7'h5f;
  localparam logic [6:0] FUNC_OD_MASK       = 7'h41;
  localparam logic [6:0] FUNC_IN_MASK       = 7'h1c;
  localparam logic [6:0] ACPI_PIN_MASK      = 7'h1f;

  // Feature bit positions
  localparam int unsigned STRAP_BIT_POS     = 4;
  localparam int unsigned GATE_EN_BIT_POS   = 4;

  // Reset values
  localparam logic        ACPI_EN_RESET     = 1'h0;
  localparam logic        PG_RESET          = 1'h0;
  localparam logic        BUTTON_RESET      = 1'h1;

  typedef enum logic [1:0] {
    SLEEP_S0 = 2'h0,
    SLEEP_S3 = 2'h1,
    SLEEP_S5 = 2'h2
  } app_sleep_t;

  typedef enum logic [1:0] {
    SEQ_HOLD  = 2'h0,
    SEQ_LATCH = 2'h1,
    SEQ_RUN   = 2'h2
  } app_seq_t;

endpackage

// ### app_debounce.sv
// Level debouncer for the front reset button
`timescale 1ns/1ps
module app_debounce #(
  parameter int unsigned CYCLES = app_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic raw_i,
  output logic      stable_o
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count;
  logic          differs;
  logic          done;

  if (CYCLES < 1) begin : g_chk
    $error("Debounce length must be at least one cycle");
  end

  assign differs = raw_i != stable_o;
  assign done    = count == CW'(CYCLES - 1);

  // Level must differ for the whole interval before it is taken
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count    <= '0;
      stable_o <= app_pkg::BUTTON_RESET;
    end
    else if (!differs)
    begin
      count <= '0;
    end
    else if (done)
    begin
      count    <= '0;
      stable_o <= raw_i; // RULE6
    end
    else
    begin
      count <= count + CW'(1);
    end
  end

endmodule

// ### app_pin_cell.sv
// One shared pin: GPIO or alternate function, registered drive
`timescale 1ns/1ps
module app_pin_cell #(
  parameter bit GPIO_OD = 1'b1,
  parameter bit FUNC_OD = 1'b0,
  parameter bit FUNC_IN = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic gpio_mode_i,
  input  wire logic gpio_dir_i,
  input  wire logic gpio_data_i,
  input  wire logic func_level_i,
  input  wire logic pin_i,
  output logic      pin_o,
  output logic      pin_oe_n_o,
  output logic      gpio_in_o
);

  logic gpio_o;
  logic gpio_oe_n;
  logic func_o;
  logic func_oe_n;
  logic next_o;
  logic next_oe_n;

  // Open-drain GPIO only pulls low
  assign gpio_o    = GPIO_OD ? 1'b0 : gpio_data_i;
  assign gpio_oe_n = GPIO_OD ? ~(gpio_dir_i & ~gpio_data_i) : ~gpio_dir_i;
  assign func_o    = (FUNC_IN || FUNC_OD) ? 1'b0 : func_level_i;
  assign func_oe_n = FUNC_IN ? 1'b1 : (FUNC_OD ? func_level_i : 1'b0);
  assign next_o    = gpio_mode_i ? gpio_o : func_o;
  assign next_oe_n = gpio_mode_i ? gpio_oe_n : func_oe_n;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_o      <= 1'b0;
      pin_oe_n_o <= 1'b1;
      gpio_in_o  <= 1'b0;
    end
    else
    begin
      pin_o      <= next_o;
      pin_oe_n_o <= next_oe_n;
      gpio_in_o  <= pin_i;
    end
  end

endmodule

// ### app_props.sv
// Checker for the ACPI power pin block
`timescale 1ns/1ps
module app_props #(
  parameter int unsigned DEBOUNCE_CYCLES = 8
) (
  input wire logic       CLOCK_I,
  input wire logic       RESET_I,
  input wire logic       HOST_SUPPLY_OK_I,
  input wire logic       SLEEP_S3_N_I,
  input wire logic       STRAP_I,
  input wire logic       STANDBY_GATE_EN_I,
  input wire logic       WATCHDOG_EXPIRED_I,
  input wire logic [6:0] GPIO_MODE_I,
  input wire logic [6:0] GPIO_DIR_I,
  input wire logic [6:0] GPIO_DATA_I,
  input wire logic [6:0] PIN_I,
  input wire logic [6:0] PIN_O,
  input wire logic [6:0] PIN_OE_N_O,
  input wire logic       RESUME_RESET_O,
  input wire logic       RESUME_RESET_OE_N_O,
  input wire logic       STRAP_PD_O,
  input wire logic       ACPI_FEATURE_EN_O,
  input wire logic       POWER_GOOD_OE_N_O,
  input wire logic       FRONT_RESET_PRESS_O,
  input wire logic [1:0] SLEEP_STATE_O
);
  logic        live;
  logic [31:0] low_run;
  always_ff @(posedge CLOCK_I or posedge RESET_I)
    if (RESET_I)
    begin
      live    <= 1'b0;
      low_run <= 32'h0;
    end
    else
    begin
      live    <= 1'b1;
      low_run <= PIN_I[3] ? 32'h0 : low_run + 32'h1;
    end
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);
  resume_strap_a: assert property (
    STRAP_PD_O == !RESUME_RESET_OE_N_O && !RESUME_RESET_O) else $error("resume window off");
  feature_hold_a: assert property (
    !RESUME_RESET_OE_N_O |-> !ACPI_FEATURE_EN_O) else $error("feature early");
  feature_latch_a: assert property (
    $rose(RESUME_RESET_OE_N_O) |=> ACPI_FEATURE_EN_O == $past(STRAP_I, 2))
    else $error("strap not latched");
  pg_drop_a: assert property (
    !HOST_SUPPLY_OK_I |=> !POWER_GOOD_OE_N_O) else $error("power good stuck");
  pg_rise_a: assert property (
    live && $past(ACPI_FEATURE_EN_O) && !GPIO_MODE_I[2] && HOST_SUPPLY_OK_I && PIN_I[2]
    |=> POWER_GOOD_OE_N_O) else $error("power good missing");
  pg2_pin_a: assert property (
    live && $past(ACPI_FEATURE_EN_O && !GPIO_MODE_I[0])
    |-> !PIN_O[0] && PIN_OE_N_O[0] == POWER_GOOD_OE_N_O) else $error("second good wrong");
  sleep_track_a: assert property (
    live && $past(ACPI_FEATURE_EN_O && !GPIO_MODE_I[4]) |-> SLEEP_STATE_O ==
    (!$past(PIN_I[4]) ? 2'h2 : (!$past(SLEEP_S3_N_I) ? 2'h1 : 2'h0))) else $error("sleep wrong");
  mem_gate_a: assert property (
    live && $past(ACPI_FEATURE_EN_O && !GPIO_MODE_I[1]) |-> !PIN_OE_N_O[1] &&
    PIN_O[1] == !($past(SLEEP_STATE_O) == 2'h1 && $past(STANDBY_GATE_EN_I)))
    else $error("gate wrong");
  led_out_a: assert property (
    live && !$past(GPIO_MODE_I[5])
    |-> !PIN_OE_N_O[5] && PIN_O[5] == ($past(SLEEP_STATE_O) != 2'h0)) else $error("led wrong");
  wdog_out_a: assert property (
    live && !$past(GPIO_MODE_I[6])
    |-> !PIN_O[6] && PIN_OE_N_O[6] == !$past(WATCHDOG_EXPIRED_I)) else $error("watchdog wrong");
  gpio_od_a: assert property (
    live && $past(GPIO_MODE_I[4]) |-> !PIN_O[4] &&
    PIN_OE_N_O[4] == !$past(GPIO_DIR_I[4] && !GPIO_DATA_I[4])) else $error("gpio drive wrong");
  button_wait_a: assert property (
    $rose(FRONT_RESET_PRESS_O) |-> low_run >= DEBOUNCE_CYCLES) else $error("press too early");
endmodule
bind app_top app_props #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) props (.*);

// ### app_partner.sv
// Board side: S5 sleep line, supply good, button and pull-ups on the pads
`timescale 1ns/1ps
module app_partner (
  input  wire logic [6:0] drive_i,
  input  wire logic [6:0] oe_n_i,
  input  wire logic [6:0] ext_i,
  output logic      [6:0] pad_o
);
  // Released pads float high; far side may pull low
  assign pad_o = ext_i & (oe_n_i | drive_i);
endmodule

// ### app_top_bench.sv
// Self-checking bench for the ACPI power pin block
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("[ERR] %s expected %h seen %h", nm, exp, got); \
    end \
  end
module app_top_bench;
  localparam int unsigned DB = 8;
  logic       CLOCK_I, RESET_I, HOST_SUPPLY_OK_I, SLEEP_S3_N_I, STRAP_I;
  logic       STANDBY_GATE_EN_I, WATCHDOG_EXPIRED_I;
  logic [6:0] GPIO_MODE_I, GPIO_DIR_I, GPIO_DATA_I, PIN_I, PIN_O, PIN_OE_N_O, GPIO_IN_O, ext;
  logic       STRAP_PD_O, RESUME_RESET_O, RESUME_RESET_OE_N_O, ACPI_FEATURE_EN_O;
  logic       POWER_GOOD_O, POWER_GOOD_OE_N_O, FRONT_RESET_PRESS_O;
  logic [1:0] SLEEP_STATE_O;
  int         err_count, comparisons, cyc;
  app_top #(.DEBOUNCE_CYCLES(DB)) uut (.*);
  app_partner board (.drive_i(PIN_O), .oe_n_i(PIN_OE_N_O), .ext_i(ext), .pad_o(PIN_I));
  initial
  begin
    CLOCK_I = 1'b0;
    forever #20 CLOCK_I = ~CLOCK_I;
  end
  task automatic summarize();
    $display("Checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge CLOCK_I)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_count++;
      summarize();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge CLOCK_I);
    #1;
  endtask
  task automatic t_reset(input logic s);
    @(posedge CLOCK_I);
    RESET_I <= 1'b1;
    STRAP_I <= s;
    wt(5);
    `CHK("pd in reset", 1'b1, STRAP_PD_O)
    @(posedge CLOCK_I);
    RESET_I <= 1'b0;
    wt(app_pkg::RESUME_HOLD_CYCLES);
    `CHK("pd held", 1'b1, STRAP_PD_O)
    `CHK("resume held", 2'h0, {RESUME_RESET_O, RESUME_RESET_OE_N_O})
    wt(1);
    `CHK("pd off", 1'b0, STRAP_PD_O)
    `CHK("resume off", 1'b1, RESUME_RESET_OE_N_O)
    wt(1);
    `CHK("feature", s, ACPI_FEATURE_EN_O)
  endtask
  task automatic t_off();
    wt(3);
    `CHK("gate as gpio", 1'b0, PIN_O[1])
    `CHK("good ignored", 1'b0, POWER_GOOD_OE_N_O)
  endtask
  task automatic t_power();
    for (int i = 0; i < 5; i++)
    begin
      @(posedge CLOCK_I);
      HOST_SUPPLY_OK_I <= i[0];
      ext[2] <= i[1];
      wt(2);
      `CHK("power good", i == 3, POWER_GOOD_OE_N_O)
      `CHK("second good", i == 3, PIN_OE_N_O[0])
      `CHK("good drive", 1'b0, POWER_GOOD_O)
    end
  endtask
  task automatic t_sleep();
    logic [1:0] st;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge CLOCK_I);
      SLEEP_S3_N_I <= i[0];
      ext[4] <= i[1];
      STANDBY_GATE_EN_I <= i[2];
      wt(3);
      st = !i[1] ? 2'h2 : (!i[0] ? 2'h1 : 2'h0);
      `CHK("sleep", st, SLEEP_STATE_O)
      `CHK("gate", !(st == 2'h1 && i[2]), PIN_O[1])
      `CHK("led", st != 2'h0, PIN_O[5])
    end
  endtask
  task automatic pad3(input logic v, input int n);
    @(posedge CLOCK_I);
    ext[3] <= v;
    wt(n);
  endtask
  task automatic t_button();
    pad3(1'b0, DB - 2);
    pad3(1'b1, DB + 4);
    `CHK("glitch", 1'b0, FRONT_RESET_PRESS_O)
    pad3(1'b0, DB + 4);
    `CHK("press", 1'b1, FRONT_RESET_PRESS_O)
    pad3(1'b1, DB + 4);
    `CHK("release", 1'b0, FRONT_RESET_PRESS_O)
  endtask
  task automatic t_gpio();
    logic [6:0] d;
    logic [6:0] dir;
    for (int i = 0; i < 3; i++)
    begin
      d = i[0] ? 7'h2a : 7'h55;
      dir = (i == 2) ? 7'h00 : 7'h7f;
      @(posedge CLOCK_I);
      GPIO_MODE_I <= 7'h7f;
      GPIO_DIR_I <= dir;
      GPIO_DATA_I <= d;
      ext <= 7'h7f;
      wt(3);
      `CHK("gpio oe", (d & app_pkg::GPIO_OD_MASK) | ~dir, PIN_OE_N_O)
      `CHK("gpio out", d & 7'h20, PIN_O)
      `CHK("gpio in", d | ~dir, GPIO_IN_O)
    end
    for (int i = 0; i < 2; i++)
    begin
      @(posedge CLOCK_I);
      GPIO_MODE_I <= 7'h00;
      WATCHDOG_EXPIRED_I <= !i[0];
      wt(2);
      `CHK("watchdog", i[0], PIN_OE_N_O[6])
    end
  endtask
  initial
  begin
    RESET_I = 1'b1;
    HOST_SUPPLY_OK_I = 1'b1;
    SLEEP_S3_N_I = 1'b1;
    STRAP_I = 1'b0;
    STANDBY_GATE_EN_I = 1'b0;
    WATCHDOG_EXPIRED_I = 1'b0;
    GPIO_MODE_I = 7'h00;
    GPIO_DIR_I = 7'h7f;
    GPIO_DATA_I = 7'h00;
    ext = 7'h7f;
    err_count = 0;
    comparisons = 0;
    cyc = 0;
    t_reset(1'b0);
    t_off();
    t_reset(1'b1);
    t_power();
    t_sleep();
    t_button();
    t_gpio();
    summarize();
  end
endmodule
